// ### shared/timer_two_cfg.svh
`ifndef TIMER_TWO_CFG_SVH
`define TIMER_TWO_CFG_SVH

// Register indices, one aligned 32-bit word each
`define IDX_CONTROL         8'hC8
`define IDX_MODE            8'hC9
`define IDX_RCMP_LOW        8'hCA
`define IDX_RCMP_HIGH       8'hCB
`define IDX_COUNT_LOW       8'hCC
`define IDX_COUNT_HIGH      8'hCD
`define IDX_CAPTURE_CTRL    8'hD0
`define IDX_CAPTURE0        8'hD4
`define IDX_CAPTURE1        8'hD8
`define IDX_CAPTURE2        8'hDC
`define IDX_IRQ_STATUS      8'hE0
`define IDX_IRQ_MASK        8'hE4
`define IDX_IRQ_ENABLE      8'hE8

// Byte addresses: four times the index
`define ADDR_CONTROL        {`IDX_CONTROL, 2'b00}
`define ADDR_MODE           {`IDX_MODE, 2'b00}
`define ADDR_RCMP_LOW       {`IDX_RCMP_LOW, 2'b00}
`define ADDR_RCMP_HIGH      {`IDX_RCMP_HIGH, 2'b00}
`define ADDR_COUNT_LOW      {`IDX_COUNT_LOW, 2'b00}
`define ADDR_COUNT_HIGH     {`IDX_COUNT_HIGH, 2'b00}
`define ADDR_CAPTURE_CTRL   {`IDX_CAPTURE_CTRL, 2'b00}
`define ADDR_CAPTURE0       {`IDX_CAPTURE0, 2'b00}
`define ADDR_CAPTURE1       {`IDX_CAPTURE1, 2'b00}
`define ADDR_CAPTURE2       {`IDX_CAPTURE2, 2'b00}
`define ADDR_IRQ_STATUS     {`IDX_IRQ_STATUS, 2'b00}
`define ADDR_IRQ_MASK       {`IDX_IRQ_MASK, 2'b00}
`define ADDR_IRQ_ENABLE     {`IDX_IRQ_ENABLE, 2'b00}

// Prescaler terminal counts, divide ratio minus one
`define DIV_LAST_1          9'h000
`define DIV_LAST_4          9'h003
`define DIV_LAST_16         9'h00F
`define DIV_LAST_32         9'h01F
`define DIV_LAST_64         9'h03F
`define DIV_LAST_128        9'h07F
`define DIV_LAST_256        9'h0FF
`define DIV_LAST_512        9'h1FF

// Control register fields
`define CTL_FLAG_BIT        7
`define CTL_RUN_BIT         2
`define CTL_MODE_BIT        0
`define CTL_WRITE_MASK      8'h85

// Mode register fields
`define MOD_RELOAD_EN_BIT   7
`define MOD_PRESCALE_HI     6
`define MOD_PRESCALE_LO     4
`define MOD_CAP_CLEAR_BIT   3
`define MOD_CMP_CLEAR_BIT   2
`define MOD_TRIG_HI         1
`define MOD_TRIG_LO         0

// Reset values
`define RESET_BYTE          8'h00
`define RESET_WORD          16'h0000
`define COUNT_MAX           16'hFFFF

// Interrupt status bit positions
`define IRQ_FLAG_BIT        0
`define IRQ_CAP_LO          1
`define IRQ_WIDTH           4

// Bus answers
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// ### shared/timer_two_pkg.sv
`default_nettype none
package timer_two_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] count_t;
    typedef logic [2:0]  prescale_t;
endpackage : timer_two_pkg
`default_nettype wire

// ### verilog/timer2_reload_compare_unit.sv
// How it works
// - Counter is 16 bits, high and low bytes, both software read/write.
// - Control bit 0 picks auto-reload (0) or compare (1) mode.
// - Counter advances only while run bit (control bit 2) is set.
// - Mode bits 6:4 pick prescale 1,4,16,32,64,128,256,512.
// - Flag at control bit 7 sets on overflow or compare match.
// - Interrupt requested while flag, timer enable and global enable set.
// - Reload trigger copies reload value only when mode bit 7 set.
// - Trigger select: 00 overflow, 01..11 capture channel 0..2.
// - Auto-reload mode with mode bit 3: capture clears counter.
// - Compare mode with mode bit 2: match clears counter.
// - Reload/compare low byte serves as compare or reload low byte.
// - Three capture channels, each with its own 16-bit capture pair.
// - Compare match on the tick where counter plus one equals reload/compare bytes.
// - Reload/compare high byte serves as compare or reload high byte.
// - With capture clear set, capture clears only, no reload.
// - Enabled channel event copies running count into its capture pair.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "timer_two_cfg.svh"
`default_nettype none

module timer2_reload_compare_unit (
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [9:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [9:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic [2:0]  capture_event, // Capture pulses, per channel
    output logic             timer_irq,     // Gated timer interrupt request
    output logic             irq            // Masked sticky-status interrupt
);

    timer_two_pkg::byte_t     timer_two_control;
    timer_two_pkg::byte_t     timer_two_mode;
    timer_two_pkg::byte_t     reload_compare_low;
    timer_two_pkg::byte_t     reload_compare_high;
    timer_two_pkg::byte_t     count_high_byte;
    timer_two_pkg::byte_t     count_low_byte;
    logic [2:0]               capture_enable;
    timer_two_pkg::count_t    capture_value [3];
    logic [1:0]               irq_enable;
    logic [`IRQ_WIDTH-1:0]    irq_status;
    logic [`IRQ_WIDTH-1:0]    irq_mask;
    logic [8:0]               prescale_count;
    logic                     tick;
    logic [9:0]               aw_addr;
    logic                     aw_held;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     w_held;
    logic                     wr_fire;
    logic                     rd_fire;

    // Divide ratio minus one for a prescale code
    function automatic logic [8:0] div_limit(
        input timer_two_pkg::prescale_t code);
        unique case (code)
            3'b000:  div_limit = `DIV_LAST_1;
            3'b001:  div_limit = `DIV_LAST_4;
            3'b010:  div_limit = `DIV_LAST_16;
            3'b011:  div_limit = `DIV_LAST_32;
            3'b100:  div_limit = `DIV_LAST_64;
            3'b101:  div_limit = `DIV_LAST_128;
            3'b110:  div_limit = `DIV_LAST_256;
            3'b111:  div_limit = `DIV_LAST_512;
        endcase
    endfunction : div_limit

    // Byte lane 0 write of an address
    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        hit = wr_fire && (a == r) && w_strb[0];
    endfunction : hit

    wire logic        run       = timer_two_control[`CTL_RUN_BIT];
    wire logic        cmp_mode  = timer_two_control[`CTL_MODE_BIT];
    wire timer_two_pkg::count_t count =
        {count_high_byte, count_low_byte};
    wire timer_two_pkg::count_t rcmp =
        {reload_compare_high, reload_compare_low};
    wire logic [2:0]  cap_hit   = capture_event & capture_enable;
    wire logic        overflow  = tick && count == `COUNT_MAX;
    wire logic        match     = tick && cmp_mode
                                  && (count + 16'h0001) == rcmp;
    wire logic [1:0]  trig_sel  =
        timer_two_mode[`MOD_TRIG_HI:`MOD_TRIG_LO];
    wire logic        trig_cap  = trig_sel != 2'b00
                                  && cap_hit[trig_sel - 2'b01];
    wire logic        cap_clear = !cmp_mode && |cap_hit
                                  && timer_two_mode[`MOD_CAP_CLEAR_BIT];
    wire logic        reload    = timer_two_mode[`MOD_RELOAD_EN_BIT]
                                  && (trig_sel == 2'b00 ? overflow
                                                        : trig_cap);

    // Prescaler producing one tick per selected ratio, only while running
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            prescale_count <= 9'h000;
            tick           <= 1'b0;
        end else if (prescale_count >= div_limit(timer_two_mode[
                `MOD_PRESCALE_HI:`MOD_PRESCALE_LO])) begin
            prescale_count <= 9'h000;
            tick           <= 1'b1;
        end else begin
            prescale_count <= prescale_count + 9'h001;
            tick           <= 1'b0;
        end
    end

    // Counter update: clear, reload, software write, count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_high_byte <= `RESET_BYTE;
            count_low_byte  <= `RESET_BYTE;
        end else if (cap_clear) begin
            count_high_byte <= `RESET_BYTE;
            count_low_byte  <= `RESET_BYTE;
        end else if (match && timer_two_mode[`MOD_CMP_CLEAR_BIT]) begin
            count_high_byte <= `RESET_BYTE;
            count_low_byte  <= `RESET_BYTE;
        end else if (reload && !cmp_mode) begin
            count_high_byte <= reload_compare_high;
            count_low_byte  <= reload_compare_low;
        end else begin
            if (tick && run) begin
                {count_high_byte, count_low_byte} <= count + 16'h0001;
            end
            if (hit(aw_addr, `ADDR_COUNT_HIGH)) begin
                count_high_byte <= w_data[7:0];
            end
            if (hit(aw_addr, `ADDR_COUNT_LOW)) begin
                count_low_byte <= w_data[7:0];
            end
        end
    end

    // Capture registers copy the running count per channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                capture_value[i] <= `RESET_WORD;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (cap_hit[i]) begin
                    capture_value[i] <= count;
                end
            end
        end
    end

    // Control register: flag set by hardware wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_two_control <= `RESET_BYTE;
        end else begin
            if (hit(aw_addr, `ADDR_CONTROL)) begin
                timer_two_control <= w_data[7:0] & `CTL_WRITE_MASK;
            end
            if (overflow || match) begin
                timer_two_control[`CTL_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Configuration registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_two_mode      <= `RESET_BYTE;
            reload_compare_low  <= `RESET_BYTE;
            reload_compare_high <= `RESET_BYTE;
            capture_enable      <= 3'b000;
            irq_mask            <= {`IRQ_WIDTH{1'b0}};
            irq_enable          <= 2'b00;
        end else begin
            if (hit(aw_addr, `ADDR_MODE)) begin
                timer_two_mode <= w_data[7:0];
            end
            if (hit(aw_addr, `ADDR_RCMP_LOW)) begin
                reload_compare_low <= w_data[7:0];
            end
            if (hit(aw_addr, `ADDR_RCMP_HIGH)) begin
                reload_compare_high <= w_data[7:0];
            end
            if (hit(aw_addr, `ADDR_CAPTURE_CTRL)) begin
                capture_enable <= w_data[2:0];
            end
            if (hit(aw_addr, `ADDR_IRQ_MASK)) begin
                irq_mask <= w_data[`IRQ_WIDTH-1:0];
            end
            if (hit(aw_addr, `ADDR_IRQ_ENABLE)) begin
                irq_enable <= w_data[1:0];
            end
        end
    end

    // Sticky event status, cleared by a read; new events win
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= {`IRQ_WIDTH{1'b0}};
        end else begin
            if (rd_fire && s_axi_araddr == `ADDR_IRQ_STATUS) begin
                irq_status <= {`IRQ_WIDTH{1'b0}};
            end
            if (overflow || match) begin
                irq_status[`IRQ_FLAG_BIT] <= 1'b1;
            end
            for (int i = 0; i < 3; i++) begin
                if (cap_hit[i]) begin
                    irq_status[`IRQ_CAP_LO + i] <= 1'b1;
                end
            end
        end
    end

    // Interrupt outputs, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq <= 1'b0;
            irq       <= 1'b0;
        end else begin
            timer_irq <= timer_two_control[`CTL_FLAG_BIT]
                         && irq_enable[0] && irq_enable[1];
            irq       <= |(irq_status & irq_mask);
        end
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Write channel: hold address and data, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 10'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= valid_addr(aw_addr) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Mapped-address check
    function automatic logic valid_addr(input logic [9:0] a);
        unique case (a)
            `ADDR_CONTROL, `ADDR_MODE, `ADDR_RCMP_LOW, `ADDR_RCMP_HIGH,
            `ADDR_COUNT_LOW, `ADDR_COUNT_HIGH, `ADDR_CAPTURE_CTRL,
            `ADDR_CAPTURE0, `ADDR_CAPTURE1, `ADDR_CAPTURE2,
            `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK,
            `ADDR_IRQ_ENABLE: valid_addr = 1'b1;
            default:          valid_addr = 1'b0;
        endcase
    endfunction : valid_addr

    // Read channel: one read at a time, data one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= valid_addr(s_axi_araddr) ? `RESP_OKAY
                                                      : `RESP_SLVERR;
            unique case (s_axi_araddr)
                `ADDR_CONTROL:      s_axi_rdata <= {24'h0, timer_two_control};
                `ADDR_MODE:         s_axi_rdata <= {24'h0, timer_two_mode};
                `ADDR_RCMP_LOW:     s_axi_rdata <= {24'h0, reload_compare_low};
                `ADDR_RCMP_HIGH:    s_axi_rdata <= {24'h0, reload_compare_high};
                `ADDR_COUNT_LOW:    s_axi_rdata <= {24'h0, count_low_byte};
                `ADDR_COUNT_HIGH:   s_axi_rdata <= {24'h0, count_high_byte};
                `ADDR_CAPTURE_CTRL: s_axi_rdata <= {29'h0, capture_enable};
                `ADDR_CAPTURE0:     s_axi_rdata <= {16'h0, capture_value[0]};
                `ADDR_CAPTURE1:     s_axi_rdata <= {16'h0, capture_value[1]};
                `ADDR_CAPTURE2:     s_axi_rdata <= {16'h0, capture_value[2]};
                `ADDR_IRQ_STATUS:   s_axi_rdata <= {28'h0, irq_status};
                `ADDR_IRQ_MASK:     s_axi_rdata <= {28'h0, irq_mask};
                `ADDR_IRQ_ENABLE:   s_axi_rdata <= {30'h0, irq_enable};
                default:            s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : timer2_reload_compare_unit

`default_nettype wire

// ### tb/timer2_reload_compare_unit_sva.sv
`timescale 1ns/100ps
`default_nettype none
module timer2_unit_checker (
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Sync reset, active low
    input wire logic        s_axi_awvalid, // Write address valid
    input wire logic        s_axi_awready, // Write address ready
    input wire logic        s_axi_wvalid,  // Write data valid
    input wire logic        s_axi_wready,  // Write data ready
    input wire logic        s_axi_bvalid,  // Write response valid
    input wire logic        s_axi_bready,  // Write response ready
    input wire logic        s_axi_arvalid, // Read address valid
    input wire logic        s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata,   // Read data
    input wire logic        s_axi_rvalid,  // Read data valid
    input wire logic        s_axi_rready,  // Read data ready
    input wire logic        timer_irq,     // Timer request
    input wire logic        irq            // Status request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshake steps
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_b_follows; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
    property p_r_follows; s_rd_taken |=> s_axi_rvalid; endproperty
    property p_w_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_r_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_ready_back;
        s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
    endproperty
    property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    property p_tirq_sw; $fell(timer_irq) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    property p_irq_clear;
        $fell(irq) |-> s_axi_rvalid || $past(s_axi_rvalid) ||
            $past(s_axi_rvalid, 2) || s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    // Bus and request checks
    a_b_follows: assert property (p_b_follows) else $error("late bvalid");
    a_r_follows: assert property (p_r_follows) else $error("late rvalid");
    a_w_refused: assert property (p_w_refused) else $error("write ready");
    a_r_refused: assert property (p_r_refused) else $error("read ready");
    a_b_once: assert property (p_b_once) else $error("bvalid stuck");
    a_r_once: assert property (p_r_once) else $error("rvalid stuck");
    a_ready_back: assert property (p_ready_back) else $error("no ready");
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
    a_tirq_sw: assert property (p_tirq_sw) else $error("irq self clear");
    a_irq_clear: assert property (p_irq_clear) else $error("irq dropped");
endmodule : timer2_unit_checker
bind timer2_reload_compare_unit timer2_unit_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_irq(timer_irq), .irq(irq));
`default_nettype wire

// ### tb/timer2_reload_compare_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_two_cfg.svh"
module timer2_reload_compare_unit_tb;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, fl;
    logic        awready, wready, bvalid, arready, rvalid, timer_irq, irq;
    logic [9:0]  awaddr, araddr;
    logic [7:0]  ctl;
    logic [31:0] wdata, rdata, rv;
    logic [1:0]  bresp, rresp;
    logic [2:0]  cap;
    logic [15:0] v, c;
    int          err_total, n_tests;
    logic [9:0]  tab [13] = '{`ADDR_CONTROL, `ADDR_MODE, `ADDR_RCMP_LOW,
        `ADDR_RCMP_HIGH, `ADDR_COUNT_LOW, `ADDR_COUNT_HIGH, `ADDR_CAPTURE_CTRL,
        `ADDR_CAPTURE0, `ADDR_CAPTURE1, `ADDR_CAPTURE2, `ADDR_IRQ_STATUS,
        `ADDR_IRQ_MASK, `ADDR_IRQ_ENABLE};
    timer2_reload_compare_unit u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .capture_event(cap),
        .timer_irq(timer_irq), .irq(irq));
    function automatic int div_of(input int k);
        return k == 0 ? 1 : (k < 3 ? 4 ** k : 1 << (k + 2));
    endfunction : div_of
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        n_tests++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_total++;
            $display("CHECK FAILED t=%0t %h not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d,
                          input logic [1:0] er = 2'b00);
        logic ad, wd;
        ad = 0; wd = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
            if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
        end while (!bvalid);
        chk(bresp, er);
    endtask : bus_wr
    task automatic bus_rd(input logic [9:0] a, input logic [1:0] er = 2'b00);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rv = rdata;
        chk(rresp, er);
    endtask : bus_rd
    task automatic set16(input logic [9:0] a, input logic [15:0] d);
        bus_wr(a, {24'h0000_00, d[7:0]});
        bus_wr(a + 10'h004, {24'h0000_00, d[15:8]});
    endtask : set16
    task automatic cnt();
        bus_rd(`ADDR_COUNT_LOW);
        v[7:0] = rv[7:0];
        bus_rd(`ADDR_COUNT_HIGH);
        v[15:8] = rv[7:0];
    endtask : cnt
    task automatic run(input int n);
        bus_wr(`ADDR_CONTROL, {24'h0000_00, ctl | 8'h04});
        repeat (n) @(posedge aclk);
        bus_rd(`ADDR_CONTROL);
        fl = rv[7];
        bus_wr(`ADDR_CONTROL, {24'h0000_00, ctl});
    endtask : run
    task automatic pulse(input int ch);
        @(posedge aclk);
        cap <= 3'b001 << ch;
        @(posedge aclk);
        cap <= 3'b000;
    endtask : pulse
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // Free running system clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Hang guard
    initial begin
        #400_000;
        err_total++;
        finish_test();
    end
    // Test sequence
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; cap = 3'b000;
        err_total = 0; n_tests = 0; ctl = 8'h00;
        void'($urandom(32'hb47b357d));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (tab[i]) begin bus_rd(tab[i]); chk(rv, 0); end
        bus_wr(10'h3F0, 32'h0000_00FF, `RESP_SLVERR);
        bus_rd(10'h3F0, `RESP_SLVERR);
        chk(rv, 0);
        bus_wr(`ADDR_CONTROL, 32'h0000_00FB);
        bus_rd(`ADDR_CONTROL);
        chk(rv, 32'h0000_0081);
        bus_wr(`ADDR_CONTROL, 32'h0000_0000);
        for (int k = 1; k < 6; k++) begin
            c = $urandom_range(0, 255);
            bus_wr(tab[k], {16'h0000, c});
            bus_rd(tab[k]);
            chk(rv, {16'h0000, c});
        end
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            set16(`ADDR_COUNT_LOW, 16'h0000);
            bus_wr(`ADDR_MODE, k << 4);
            run(20 * div_of(k));
            cnt();
            chk_rng(v, 19, (20 * div_of(k) + 12) / div_of(k) + 1);
        end
        repeat (20) @(posedge aclk);
        c = v;
        cnt();
        chk(v, c);
        $display("test prescale done");
        bus_wr(`ADDR_IRQ_MASK, 32'h0000_0001);
        bus_wr(`ADDR_IRQ_ENABLE, 32'h0000_0003);
        set16(`ADDR_COUNT_LOW, 16'hFFFE);
        bus_wr(`ADDR_MODE, 32'h0000_0000);
        bus_wr(`ADDR_CONTROL, 32'h0000_0004);
        for (int e = 0; e < 4; e++) begin
            bus_wr(`ADDR_IRQ_ENABLE, e);
            repeat (3) @(posedge aclk);
            chk(timer_irq, e == 3);
        end
        bus_rd(`ADDR_CONTROL);
        chk(rv[7], 1);
        chk(irq, 1);
        bus_rd(`ADDR_IRQ_STATUS);
        chk(rv[0], 1);
        repeat (3) @(posedge aclk);
        chk(irq, 0);
        bus_wr(`ADDR_CONTROL, 32'h0000_0000);
        repeat (3) @(posedge aclk);
        chk(timer_irq, 0);
        cnt();
        chk_rng(v, 1, 300);
        bus_wr(`ADDR_IRQ_MASK, 32'h0000_0000);
        set16(`ADDR_COUNT_LOW, 16'hFFFE);
        run(10);
        chk(fl, 1);
        chk(irq, 0);
        bus_rd(`ADDR_IRQ_STATUS);
        chk(rv[0], 1);
        $display("test overflow done");
        for (int le = 0; le < 2; le++) begin
            c = 16'h1000 + $urandom_range(0, 16'h7FFF);
            set16(`ADDR_RCMP_LOW, c);
            bus_wr(`ADDR_MODE, le << 7);
            set16(`ADDR_COUNT_LOW, 16'hFFF0);
            run(30);
            cnt();
            chk_rng(v, (le ? c : 0) + 10, (le ? c : 0) + 60);
        end
        $display("test reload done");
        bus_wr(`ADDR_MODE, 32'h0000_0000);
        bus_wr(`ADDR_CAPTURE_CTRL, 32'h0000_0007);
        for (int ch = 0; ch < 3; ch++) begin
            c = $urandom;
            set16(`ADDR_COUNT_LOW, c);
            pulse(ch);
            bus_rd(tab[7 + ch]);
            chk(rv, {16'h0000, c});
            bus_rd(`ADDR_IRQ_STATUS);
            chk(rv[ch + 1], 1);
        end
        bus_wr(`ADDR_CAPTURE_CTRL, 32'h0000_0000);
        set16(`ADDR_COUNT_LOW, ~c);
        pulse(2);
        bus_rd(`ADDR_CAPTURE2);
        chk(rv, {16'h0000, c});
        bus_wr(`ADDR_CAPTURE_CTRL, 32'h0000_0007);
        for (int t = 1; t < 4; t++) begin
            c = $urandom;
            set16(`ADDR_RCMP_LOW, c);
            set16(`ADDR_COUNT_LOW, ~c);
            bus_wr(`ADDR_MODE, 8'h80 | t);
            pulse(t - 1);
            cnt();
            chk(v, c);
            bus_wr(`ADDR_MODE, 8'h88 | t);
            pulse(t - 1);
            cnt();
            chk(v, 0);
        end
        $display("test capture done");
        ctl = 8'h01;
        bus_wr(`ADDR_CONTROL, 32'h0000_0001);
        for (int cc = 0; cc < 2; cc++) begin
            c = 16'h0100 + $urandom_range(0, 16'h7000);
            set16(`ADDR_RCMP_LOW, c);
            bus_wr(`ADDR_MODE, cc << 2);
            set16(`ADDR_COUNT_LOW, c - 16'h0004);
            run(20);
            cnt();
            chk(fl, 1);
            chk_rng(v, cc ? 1 : c + 10, cc ? 40 : c + 40);
        end
        $display("test compare done");
        finish_test();
    end
endmodule : timer2_reload_compare_unit_tb
`default_nettype wire
